// File: logic/sdpe_cfg.svh
// Timing constants and start-up counts of the speed and direction pulse encoder.
// Assumes a 100 MHz system clock; counts are derived from times in nanoseconds.
`ifndef SDPE_CFG_SVH
`define SDPE_CFG_SVH
`define SDPE_CLK_PERIOD_NS 10
`define SDPE_PRE_LOW_NS 15000
`define SDPE_SPEED_HIGH_NS 30000
`define SDPE_CW_HIGH_NS 45000
`define SDPE_CCW_HIGH_NS 90000
`define SDPE_PRE_LOW_CYC (`SDPE_PRE_LOW_NS / `SDPE_CLK_PERIOD_NS)
`define SDPE_SPEED_CYC (`SDPE_SPEED_HIGH_NS / `SDPE_CLK_PERIOD_NS)
`define SDPE_CW_CYC (`SDPE_CW_HIGH_NS / `SDPE_CLK_PERIOD_NS)
`define SDPE_CCW_CYC (`SDPE_CCW_HIGH_NS / `SDPE_CLK_PERIOD_NS)
`define SDPE_HYST_ARM_COUNT 0
`define SDPE_DIR_ARM_PERIODS 3
`define SDPE_DIR_ARM_PULSES 2
`endif

// File: logic/sdpe_pkg.sv
// Types of the speed and direction pulse encoder.
// Assumes nothing of its surroundings.
package sdpe_pkg;
  typedef enum logic [1:0] {
    SDPE_CODE_SPEED = 2'b00,
    SDPE_CODE_CW = 2'b01,
    SDPE_CODE_CCW = 2'b10
  } sdpe_code_t;
  typedef enum logic [1:0] {
    SDPE_IDLE = 2'b00,
    SDPE_PRE_LOW = 2'b01,
    SDPE_HIGH = 2'b10
  } sdpe_state_t;
endpackage : sdpe_pkg

// File: logic/sdpe_sync.sv
// Three-stage synchroniser with agreement on the last two stages.
// Assumes a single clock domain and an asynchronous level input.
`timescale 1ns/1ps
module sdpe_sync
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic async_in,
  output logic sync_out
);
  logic s1_q;
  logic s2_q;
  logic s3_q;
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      sync_out <= 1'b0;
    end
    else if (clk_en)
    begin
      s1_q <= async_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q)
      begin
        sync_out <= s3_q;
      end
    end
  end
endmodule : sdpe_sync

// File: logic/sdpe_encoder.sv
// Speed and direction pulse encoder: turns magnetic transitions into coded current pulses.
// Assumes speed and direction comparator levels from the front end, async to sys_clk.
`timescale 1ns/1ps
`include "sdpe_cfg.svh"
module sdpe_encoder
#(
  parameter int CNT_W = 14
)
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic speed_in,
  input wire logic dir_in,
  output logic current_high,
  output logic pulse_busy,
  output sdpe_pkg::sdpe_code_t pulse_code,
  output logic dir_known,
  output logic dir_suppress_armed,
  output logic hyst_suppress_armed,
  output logic skip_event
);
  import sdpe_pkg::*;

  localparam logic [CNT_W-1:0] PRE_CYC = CNT_W'(`SDPE_PRE_LOW_CYC);
  localparam logic [CNT_W-1:0] SPD_CYC = CNT_W'(`SDPE_SPEED_CYC);
  localparam logic [CNT_W-1:0] CW_CYC = CNT_W'(`SDPE_CW_CYC);
  localparam logic [CNT_W-1:0] CCW_CYC = CNT_W'(`SDPE_CCW_CYC);

  function automatic logic [CNT_W-1:0] high_len(input sdpe_code_t c);
    unique case (c)
      SDPE_CODE_CW: high_len = CW_CYC;
      SDPE_CODE_CCW: high_len = CCW_CYC;
      default: high_len = SPD_CYC;
    endcase
  endfunction : high_len

  function automatic sdpe_code_t dir_code(input logic d);
    dir_code = d ? SDPE_CODE_CW : SDPE_CODE_CCW;
  endfunction : dir_code

  logic spd_s;
  logic dir_s;
  logic spd_prev_q;
  logic init_q;
  logic rise;
  logic fall;
  logic edge_ev;
  sdpe_state_t state_q;
  logic [CNT_W-1:0] cnt_q;
  logic [1:0] periods_q;
  logic [1:0] pulses_q;
  logic [2:0] settle_q;
  sdpe_code_t next_code;
  logic dir_valid_q;
  sdpe_code_t dir_code_q;
  logic first_done_q;
  logic fire;

  sdpe_sync u_sync_spd
  (
    .sys_clk(sys_clk),
    .rst(rst),
    .clk_en(clk_en),
    .async_in(speed_in),
    .sync_out(spd_s)
  );
  sdpe_sync u_sync_dir
  (
    .sys_clk(sys_clk),
    .rst(rst),
    .clk_en(clk_en),
    .async_in(dir_in),
    .sync_out(dir_s)
  );

  assign rise = init_q && spd_s && !spd_prev_q;
  assign fall = init_q && !spd_s && spd_prev_q;
  assign edge_ev = rise || fall;
  // First pulse only on a rising edge; edges during a pulse are skipped
  assign fire = (state_q == SDPE_IDLE) && (first_done_q ? edge_ev : rise);
  // A rising edge after the first uses its own direction sample, so a reversal costs one pulse at most
  assign next_code = (rise && periods_q != 2'h0) ? dir_code(dir_s) :
    (dir_valid_q ? dir_code_q : SDPE_CODE_SPEED);

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      spd_prev_q <= 1'b0;
      init_q <= 1'b0;
      settle_q <= 3'h0;
    end
    else if (clk_en)
    begin
      spd_prev_q <= spd_s;
      // Edges count only once the synchronisers show the real pin level
      if (settle_q != 3'h4)
      begin
        settle_q <= settle_q + 3'h1;
      end
      init_q <= init_q || (settle_q == 3'h4);
    end
  end

  // Period and direction tracking: direction sampled at each rising edge after the first
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      periods_q <= 2'h0;
      dir_valid_q <= 1'b0;
      dir_code_q <= SDPE_CODE_SPEED;
    end
    else if (clk_en && rise)
    begin
      if (periods_q != 2'(`SDPE_DIR_ARM_PERIODS))
      begin
        periods_q <= periods_q + 2'h1;
      end
      // Direction known from the second rising edge on
      if (periods_q != 2'h0)
      begin
        dir_valid_q <= 1'b1;
        // Kept for the pulses of later falling edges
        dir_code_q <= dir_code(dir_s);
      end
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      pulses_q <= 2'h0;
      first_done_q <= 1'b0;
    end
    else if (clk_en && fire)
    begin
      first_done_q <= 1'b1;
      if (pulses_q != 2'h3)
      begin
        pulses_q <= pulses_q + 2'h1;
      end
    end
  end

  // Pulse sequencer; only edges start pulses, no standstill timer
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      state_q <= SDPE_IDLE;
      cnt_q <= '0;
      current_high <= 1'b0;
      pulse_busy <= 1'b0;
      pulse_code <= SDPE_CODE_SPEED;
      skip_event <= 1'b0;
    end
    else if (clk_en)
    begin
      skip_event <= edge_ev && (state_q != SDPE_IDLE);
      unique case (state_q)
        SDPE_IDLE:
        begin
          if (fire)
          begin
            state_q <= SDPE_PRE_LOW;
            cnt_q <= PRE_CYC - CNT_W'(1);
            pulse_busy <= 1'b1;
            current_high <= 1'b0;
            pulse_code <= next_code;
          end
        end
        SDPE_PRE_LOW:
        begin
          if (cnt_q == '0)
          begin
            state_q <= SDPE_HIGH;
            cnt_q <= high_len(pulse_code) - CNT_W'(1);
            current_high <= 1'b1;
          end
          else
          begin
            cnt_q <= cnt_q - CNT_W'(1);
          end
        end
        SDPE_HIGH:
        begin
          if (cnt_q == '0)
          begin
            state_q <= SDPE_IDLE;
            current_high <= 1'b0;
            pulse_busy <= 1'b0;
          end
          else
          begin
            cnt_q <= cnt_q - CNT_W'(1);
          end
        end
        default:
        begin
          state_q <= SDPE_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      dir_known <= 1'b0;
      dir_suppress_armed <= 1'b0;
      hyst_suppress_armed <= 1'b1;
    end
    else if (clk_en)
    begin
      dir_known <= dir_valid_q;
      hyst_suppress_armed <= 1'b1;
      dir_suppress_armed <= (periods_q == 2'(`SDPE_DIR_ARM_PERIODS));
    end
  end

  property p_pre_low_len;
    @(posedge sys_clk) disable iff (rst || !clk_en)
    fire |=> !current_high [*8];
  endproperty
  a_pre_low_len: assert property (p_pre_low_len) else $error("pre-low too short");

  property p_no_overlap;
    @(posedge sys_clk) disable iff (rst)
    (state_q != SDPE_IDLE && cnt_q != '0) |=> state_q == $past(state_q);
  endproperty
  a_no_overlap: assert property (p_no_overlap) else $error("pulse overlap");

  property p_first_rise;
    @(posedge sys_clk) disable iff (rst || !clk_en)
    ($rose(pulse_busy) && !$past(first_done_q)) |-> $past(spd_s);
  endproperty
  a_first_rise: assert property (p_first_rise) else $error("first pulse not on rise");

  property p_hyst;
    @(posedge sys_clk) disable iff (rst)
    ##1 hyst_suppress_armed;
  endproperty
  a_hyst: assert property (p_hyst) else $error("hysteresis not armed");

  property p_high_after_pre;
    @(posedge sys_clk) disable iff (rst || !clk_en)
    $rose(current_high) |-> $past(state_q) == SDPE_PRE_LOW;
  endproperty
  a_high_after_pre: assert property (p_high_after_pre) else $error("high without pre-low");

  property p_speed_code;
    @(posedge sys_clk) disable iff (rst || !clk_en)
    (fire && periods_q == 2'h0) |=> pulse_code == SDPE_CODE_SPEED;
  endproperty
  a_speed_code: assert property (p_speed_code) else $error("speed code expected");

  property p_dir_code;
    @(posedge sys_clk) disable iff (rst || !clk_en)
    (fire && rise && periods_q != 2'h0) |=> pulse_code == dir_code($past(dir_s));
  endproperty
  a_dir_code: assert property (p_dir_code) else $error("direction code wrong");

  property p_dir_arm;
    @(posedge sys_clk) disable iff (rst || !clk_en)
    (periods_q == 2'h3) |=> dir_suppress_armed;
  endproperty
  a_dir_arm: assert property (p_dir_arm) else $error("direction suppression not armed");

  c_cw: cover property (@(posedge sys_clk) fire && dir_code_q == SDPE_CODE_CW && dir_valid_q);
  c_ccw: cover property (@(posedge sys_clk) fire && dir_code_q == SDPE_CODE_CCW && dir_valid_q);
  c_skip: cover property (@(posedge sys_clk) skip_event);
  c_start: cover property (@(posedge sys_clk) pulses_q == 2'h2 && dir_known);
endmodule : sdpe_encoder

// File: dv/sdpe_receiver.sv
// Receiver model: times each high phase of the current and classifies it.
// Assumes the current level is seen on sys_clk cycles at 100 MHz.
`timescale 1ns/1ps
module sdpe_receiver
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic current_high,
  output logic [1:0] rx_code,
  output logic [31:0] rx_count
);
  logic [31:0] width_q;

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      width_q <= '0;
      rx_code <= 2'h3;
      rx_count <= '0;
    end
    else if (current_high)
      width_q <= width_q + 32'h1;
    else if (width_q != '0)
    begin
      // Tolerance windows around each nominal width
      rx_code <= (width_q >= 32'ha41 && width_q <= 32'hd2f) ? 2'h0 :
        (width_q >= 32'hf61 && width_q <= 32'h13c6) ? 2'h1 :
        (width_q >= 32'h1ec3 && width_q <= 32'h278d) ? 2'h2 : 2'h3;
      rx_count <= rx_count + 32'h1;
      width_q <= '0;
    end
  end
endmodule : sdpe_receiver

// File: dv/sdpe_encoder_tb.sv
// Testbench of the pulse encoder: table and random edges, receiver model on the output.
// Assumes sdpe_pkg, sdpe_cfg.svh, the encoder and sdpe_receiver are compiled.
`timescale 1ns/1ps
`include "sdpe_cfg.svh"
module sdpe_encoder_tb;
  import sdpe_pkg::*;
  logic sys_clk, rst, clk_en, speed_in, dir_in, rd;
  logic current_high, pulse_busy, dir_known, dir_suppress_armed, hyst_suppress_armed;
  logic skip_event;
  sdpe_code_t pulse_code, cur;
  logic [1:0] rx_code;
  logic [31:0] rx_count;
  int bad_count, comparisons, rises, i;
  int seed = 32'h32ed32c9;

  sdpe_encoder DUT (.sys_clk(sys_clk), .rst(rst), .clk_en(clk_en), .speed_in(speed_in),
    .dir_in(dir_in), .current_high(current_high), .pulse_busy(pulse_busy),
    .pulse_code(pulse_code), .dir_known(dir_known), .dir_suppress_armed(dir_suppress_armed),
    .hyst_suppress_armed(hyst_suppress_armed), .skip_event(skip_event));
  sdpe_receiver rx (.sys_clk(sys_clk), .rst(rst), .current_high(current_high),
    .rx_code(rx_code), .rx_count(rx_count));

  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  task stop_test;
    if (bad_count == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : stop_test

  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("Error %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check

  function int high_cyc(sdpe_code_t c);
    return c == SDPE_CODE_SPEED ? `SDPE_SPEED_CYC : c == SDPE_CODE_CW ? `SDPE_CW_CYC :
      `SDPE_CCW_CYC;
  endfunction : high_cyc

  // Falling edges keep the last code
  function sdpe_code_t next_code(logic s, logic d);
    if (!s)
      return cur;
    return rises == 0 ? SDPE_CODE_SPEED : (d ? SDPE_CODE_CW : SDPE_CODE_CCW);
  endfunction : next_code

  // One magnetic edge; g adds a counter-edge during the pre-low phase
  task pulse(input logic s, input logic d, input logic g);
    int n, lo, hi, sk;
    logic [31:0] cnt0;
    cur = next_code(s, d);
    if (s)
      rises++;
    cnt0 = rx_count;
    @(negedge sys_clk);
    dir_in = d;
    repeat (8) @(negedge sys_clk);
    speed_in = s;
    n = 0;
    lo = 0;
    hi = 0;
    sk = 0;
    while (pulse_busy !== 1'b1 && n < 30)
    begin
      @(negedge sys_clk);
      n++;
    end
    while (pulse_busy === 1'b1 && n < 20000)
    begin
      if (current_high === 1'b1)
        hi++;
      else
        lo++;
      if (g && lo == 100)
        speed_in = ~s;
      if (skip_event === 1'b1)
        sk = 1;
      @(negedge sys_clk);
      n++;
    end
    if (n >= 20000)
    begin
      bad_count++;
      stop_test;
    end
    @(negedge sys_clk);
    check("pre_low", lo, `SDPE_PRE_LOW_CYC);
    check("high", hi, high_cyc(cur));
    check("pulse_code", pulse_code, cur);
    check("rx_code", rx_code, cur);
    check("rx_count", rx_count, cnt0 + 32'h1);
    check("skip_event", sk, g);
    check("dir_known", dir_known, rises >= 2);
    check("dir_suppress_armed", dir_suppress_armed, rises >= 3);
    check("hyst_suppress_armed", hyst_suppress_armed, 1'b1);
  endtask : pulse

  task quiet(input int cyc);
    int b;
    b = 0;
    repeat (cyc)
    begin
      @(negedge sys_clk);
      if (pulse_busy !== 1'b0)
        b++;
    end
    check("standstill", b, 0);
  endtask : quiet

  initial
  begin
    rst = 1'b1;
    clk_en = 1'b1;
    speed_in = 1'b1;
    dir_in = 1'b0;
    bad_count = 0;
    comparisons = 0;
    rises = 0;
    cur = SDPE_CODE_SPEED;
    repeat (12) @(negedge sys_clk);
    rst = 1'b0;
    check("hyst_suppress_armed", hyst_suppress_armed, 1'b1);
    repeat (4) @(negedge sys_clk);
    speed_in = 1'b0;
    quiet(100);
    pulse(1'b1, 1'b0, 1'b0);
    pulse(1'b0, 1'b0, 1'b0);
    pulse(1'b1, 1'b1, 1'b0);
    pulse(1'b0, 1'b0, 1'b0);
    pulse(1'b1, 1'b0, 1'b0);
    pulse(1'b0, 1'b0, 1'b1);
    quiet(500);
    for (i = 0; i < 3; i++)
    begin
      rd = 1'($random(seed));
      pulse(~speed_in, rd, 1'b0);
    end
    stop_test;
  end
endmodule : sdpe_encoder_tb
